// ===== rtl/sfr_core.sv
`timescale 1ns/10ps
`default_nettype none
`include "sfr_defines.svh"
module sfr_core (
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          reset_n,
  // Instruction in execute and enable strap
  input  wire logic [15:0]   instr,
  input  wire logic          instr_valid,
  input  wire logic          extended_set_enable_bit,
  // Core state read by the block
  input  wire logic [7:0]    working_register,
  input  wire logic [7:0]    pc_high_latch,
  input  wire logic [7:0]    pc_upper_latch,
  input  wire logic [20:0]   pc_in,
  input  wire logic [20:0]   return_stack_top,
  // Results
  output logic [11:0]        frame_pointer_three,
  output logic [20:0]        pc_out,
  output logic               pc_load,
  output logic               stack_push,
  output logic [20:0]        stack_push_data,
  output logic               stack_pop,
  output logic               busy,
  output logic [4:0]         status_flag_we
);
  import sfr_pkg::*;

  logic        rst_s1_q;          // Reset synchroniser stage one
  logic        rst_s2_q;          // Synchronised reset, active low
  sfr_op_type  op;                // Decoded class
  sfr_state_type state_q, state_d;  // Sequencer
  logic [11:0] ptr_q, ptr_d;      // Frame pointer three
  logic [20:0] pc_q, pc_d;        // Registered pc result
  logic [20:0] push_q, push_d;    // Registered push data
  logic        load_q, load_d;    // Pc load pulse
  logic        push_v_q, push_v_d; // Push pulse
  logic        pop_q, pop_d;      // Pop pulse
  logic        take_alr;          // Frame-return taken this cycle
  logic        take_ccw;          // Computed call taken this cycle

  // A class is taken only in the execute state with a valid word;
  // a word offered while the stall cycle runs is dropped
  function automatic logic sfr_taken(input sfr_state_type st,
                                     input logic          vld,
                                     input sfr_op_type    cls,
                                     input sfr_op_type    want);
    sfr_taken = (st == SFR_EXEC) && vld && (cls == want);
  endfunction

  // Reset release through two flops
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // Decoder instance
  sfr_decode sfr_decode_i (
    .instr  (instr),
    .ext_en (extended_set_enable_bit),
    .op     (op)
  );

  // Take strobes, shared by the checks below
  assign take_alr = sfr_taken(state_q, instr_valid, op, SFR_OP_ALR);
  assign take_ccw = sfr_taken(state_q, instr_valid, op, SFR_OP_CCW);

  // Next state and results
  always_comb begin
    state_d  = SFR_EXEC;
    ptr_d    = ptr_q;
    pc_d     = pc_q;
    push_d   = push_q;
    load_d   = 1'b0;
    push_v_d = 1'b0;
    pop_d    = 1'b0;
    case (state_q)
      SFR_EXEC: begin
        // Decode only on a valid instruction
        if (instr_valid && op == SFR_OP_ALR) begin
          ptr_d   = ptr_q + {6'h00, instr[5:0]};
          pc_d    = return_stack_top;
          load_d  = 1'b1;
          pop_d   = 1'b1;
          state_d = SFR_STALL;
        end else if (instr_valid && op == SFR_OP_CCW) begin
          push_d   = pc_in + `SFR_RET_STEP;
          push_v_d = 1'b1;
          pc_d     = {pc_upper_latch[4:0], pc_high_latch,
                      working_register};
          load_d   = 1'b1;
          state_d  = SFR_STALL;
        end
      end
      SFR_STALL: begin
        // Second cycle is a no-operation during refetch
        state_d = SFR_EXEC;
      end
      default: state_d = SFR_EXEC;
    endcase
  end

  // Register the state
  always_ff @(posedge clk_sys or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      state_q  <= SFR_EXEC;
      ptr_q    <= `SFR_PTR_RST;
      pc_q     <= `SFR_PC_RST;
      push_q   <= `SFR_PC_RST;
      load_q   <= 1'b0;
      push_v_q <= 1'b0;
      pop_q    <= 1'b0;
    end else begin
      state_q  <= state_d;
      ptr_q    <= ptr_d;
      pc_q     <= pc_d;
      push_q   <= push_d;
      load_q   <= load_d;
      push_v_q <= push_v_d;
      pop_q    <= pop_d;
    end
  end

  // Outputs; flags and saved registers are never written
  assign frame_pointer_three = ptr_q;
  assign pc_out              = pc_q;
  assign pc_load             = load_q;
  assign stack_push          = push_v_q;
  assign stack_push_data     = push_q;
  assign stack_pop           = pop_q;
  assign busy                = (state_q == SFR_STALL);
  assign status_flag_we      = 5'h00;

  // Checks
  // Pointer gains the literal on a taken frame-return
  a_alr_ptr_add: assert property (
    @(posedge clk_sys) disable iff (!rst_s2_q)
    take_alr |=> ptr_q == $past(ptr_q) + {6'h00, $past(instr[5:0])})
    else $error("pointer sum wrong");
  // Return loads the stack top and pops it
  a_alr_return: assert property (
    @(posedge clk_sys) disable iff (!rst_s2_q)
    take_alr |=> pc_load && stack_pop &&
                 pc_out == $past(return_stack_top))
    else $error("return not taken");
  // Return never pushes
  a_alr_no_push: assert property (
    @(posedge clk_sys) disable iff (!rst_s2_q)
    take_alr |=> !stack_push)
    else $error("push on return");
  // Every load falls in exactly one idle cycle, and the cycle after it is neither idle nor loading
  a_two_cycle: assert property (
    @(posedge clk_sys) disable iff (!rst_s2_q)
    pc_load |-> busy ##1 !busy && !pc_load)
    else $error("not two cycles");
  // The idle cycle starts nothing and keeps the pointer
  a_busy_refuse: assert property (
    @(posedge clk_sys) disable iff (!rst_s2_q)
    busy |=> !pc_load && !stack_push && !stack_pop &&
             ptr_q == $past(ptr_q))
    else $error("work started while busy");
  // Frame-return pattern decodes with the set enabled
  a_alr_decode: assert property (
    @(posedge clk_sys) disable iff (!rst_s2_q)
    (extended_set_enable_bit && instr[15:6] == 10'h3a3) |->
    op == SFR_OP_ALR)
    else $error("frame return not decoded");
  // Call pushes the address two past its own
  a_ccw_push: assert property (
    @(posedge clk_sys) disable iff (!rst_s2_q)
    take_ccw |=> stack_push &&
                 stack_push_data == $past(pc_in) + 21'h000002)
    else $error("push data wrong");
  // A push always comes with a load and never with a pop
  a_push_alone: assert property (
    @(posedge clk_sys) disable iff (!rst_s2_q)
    stack_push |-> pc_load && !stack_pop)
    else $error("push without load or with pop");
  // Target bytes come from the accumulator and the two latches
  a_ccw_target: assert property (
    @(posedge clk_sys) disable iff (!rst_s2_q)
    take_ccw |=> pc_out[7:0] == $past(working_register) &&
                 pc_out[15:8] == $past(pc_high_latch) &&
                 pc_out[20:16] == $past(pc_upper_latch[4:0]))
    else $error("call target wrong");
  // Call leaves the frame pointer alone and never pops the stack
  a_ccw_keep: assert property (
    @(posedge clk_sys) disable iff (!rst_s2_q)
    take_ccw |=> !stack_pop && ptr_q == $past(ptr_q))
    else $error("call disturbed saved state");
  // Computed call word decodes with the set enabled
  a_ccw_decode: assert property (
    @(posedge clk_sys) disable iff (!rst_s2_q)
    (extended_set_enable_bit && instr == 16'h0014) |->
    op == SFR_OP_CCW)
    else $error("computed call not decoded");
  // Nothing decodes with the extended set off
  a_ext_gate: assert property (
    @(posedge clk_sys) disable iff (!rst_s2_q)
    !extended_set_enable_bit |-> op == SFR_OP_NONE)
    else $error("decoded while disabled");
  // Without a taken word the block stays quiet
  a_idle_quiet: assert property (
    @(posedge clk_sys) disable iff (!rst_s2_q)
    (state_q == SFR_EXEC && !take_alr && !take_ccw) |=>
    !pc_load && !stack_push && !stack_pop &&
    ptr_q == $past(ptr_q) && pc_out == $past(pc_out))
    else $error("activity without a taken word");
  // Flag writes stay off on every load
  a_no_flags: assert property (
    @(posedge clk_sys) disable iff (!rst_s2_q)
    pc_load |-> status_flag_we == 5'h00)
    else $error("flags written");
endmodule
`default_nettype wire

// ===== rtl/sfr_decode.sv
`timescale 1ns/10ps
`default_nettype none
`include "sfr_defines.svh"
// Combinational decoder for the two extended instructions
module sfr_decode (
  // Instruction word and enable
  input  wire logic [15:0]       instr,
  input  wire logic              ext_en,
  // Decoded class
  output sfr_pkg::sfr_op_type    op
);
  import sfr_pkg::*;

  // Classify the word; nothing decodes with the extended set off
  always_comb begin
    op = SFR_OP_NONE;
    if (ext_en) begin
      if (instr[15:6] == `SFR_ALR_OPC) begin
        op = SFR_OP_ALR;
      end else if (instr == `SFR_CCW_OPC) begin
        op = SFR_OP_CCW;
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/sfr_defines.svh
`ifndef SFR_DEFINES_SVH
`define SFR_DEFINES_SVH
// Opcode of the add-literal-and-return form (upper ten bits)
`define SFR_ALR_OPC     10'h3a3
// Opcode of the computed call (whole word)
`define SFR_CCW_OPC     16'h0014
// Literal field position and width
`define SFR_LIT_LSB     0
`define SFR_LIT_W       6
// Program counter step to the return address
`define SFR_RET_STEP    21'h000002
// Reset values
`define SFR_PTR_RST     12'h000
`define SFR_PC_RST      21'h000000
`endif

// ===== rtl/sfr_pkg.sv
package sfr_pkg;
  // Sequencer states, Gray order along the usual path
  typedef enum logic [1:0] {
    SFR_EXEC  = 2'b00,
    SFR_STALL = 2'b01
  } sfr_state_type;
  // Instruction class seen by the decoder
  typedef enum logic [1:0] {
    SFR_OP_NONE = 2'b00,
    SFR_OP_ALR  = 2'b01,
    SFR_OP_CCW  = 2'b10
  } sfr_op_type;
endpackage

// ===== testbench/sfr_core_tb.sv
`timescale 1ns/10ps
`default_nettype none
module sfr_core_tb;
  // Stimulus and observed signals
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic        instr_valid = 1'b0;
  logic        extended_set_enable_bit = 1'b1;
  logic [7:0]  working_register = 8'h06;
  logic [7:0]  pc_high_latch = 8'h10;
  logic [7:0]  pc_upper_latch = 8'he1;
  logic [20:0] pc_in = 21'h0ffffe;
  logic [20:0] return_stack_top = 21'h1abcde;
  logic [11:0] frame_pointer_three;
  logic [20:0] pc_out, stack_push_data;
  logic        pc_load, stack_push, stack_pop, busy;
  logic [4:0]  status_flag_we;
  int          bad_count = 0, compares = 0;
  // Pulses and flag strobes packed for one compare
  wire  [20:0] flg = {12'h000, status_flag_we, pc_load, stack_push,
                      stack_pop, busy};
  wire  [20:0] ptr = {9'h000, frame_pointer_three};
  always #50 clk_sys = ~clk_sys;
  sfr_core sfr_core_i (.clk_sys, .reset_n, .instr, .instr_valid,
    .extended_set_enable_bit, .working_register, .pc_high_latch,
    .pc_upper_latch, .pc_in, .return_stack_top, .frame_pointer_three,
    .pc_out, .pc_load, .stack_push, .stack_push_data, .stack_pop, .busy,
    .status_flag_we);
  // Compare and report
  task automatic chk(input logic [20:0] g, input logic [20:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One instruction, left at the edge after it was taken
  task automatic send(input logic [15:0] w);
    @(negedge clk_sys);
    instr = w;
    instr_valid = 1'b1;
    @(negedge clk_sys);
    instr_valid = 1'b0;
  endtask
  // Frame add at the top literal, then with 5 after one spare cycle
  task automatic t_alr;
    send(16'he8ff);
    chk(ptr, 21'h00003f);
    chk(pc_out, 21'h1abcde);
    chk(flg, 21'h00000b);
    @(negedge clk_sys);
    chk(flg, 21'h000000);
    send(16'he8c5);
    chk(ptr, 21'h000044);
  endtask
  // Computed call, carry out of the low word into the push value
  task automatic t_ccw;
    send(16'h0014);
    chk(stack_push_data, 21'h100000);
    chk(pc_out, 21'h011006);
    chk(flg, 21'h00000d);
    chk(ptr, 21'h000044);
    @(negedge clk_sys);
    chk(flg, 21'h000000);
  endtask
  // Disabled set, other pointer, near opcode, request while busy
  task automatic t_refuse;
    extended_set_enable_bit = 1'b0;
    send(16'he8c5);
    chk(flg, 21'h000000);
    send(16'h0014);
    chk(flg, 21'h000000);
    extended_set_enable_bit = 1'b1;
    send(16'he885);
    chk(flg, 21'h000000);
    send(16'h0015);
    chk(flg, 21'h000000);
    chk(ptr, 21'h000044);
    @(negedge clk_sys);
    instr = 16'he8c1;
    instr_valid = 1'b1;
    @(negedge clk_sys);
    instr = 16'he8c7;
    @(negedge clk_sys);
    instr_valid = 1'b0;
    chk(ptr, 21'h000045);
    chk(flg, 21'h000000);
  endtask
  // Verdict and end of run
  task automatic wrap_up;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (6) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk(ptr, 21'h000000);
    t_alr();
    t_ccw();
    t_refuse();
    wrap_up();
  end
  // Watchdog
  initial begin
    #200000;
    bad_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
